//--- pio_pkg.sv
// Shared constants for the parallel I/O port bank.
package pio_pkg;

   // Bank geometry.
   localparam int PIO_NUM_PORTS = 6;
   localparam int PIO_PORT_W = 8;
   localparam int PIO_NUM_PINS = 48;
   localparam int PIO_NUM_GRP = 4;
   localparam int PIO_ADDR_W = 8;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [5:0] PIO_PORT_A_DATA = 6'h00;
   localparam logic [5:0] PIO_PORT_A_DIRECTION = 6'h01;
   localparam logic [5:0] PIO_PORT_A_OPTION = 6'h02;
   localparam logic [5:0] PIO_PORT_C_DATA = 6'h04;
   localparam logic [5:0] PIO_PORT_C_DIRECTION = 6'h05;
   localparam logic [5:0] PIO_PORT_C_OPTION = 6'h06;
   localparam logic [5:0] PIO_PORT_B_DATA = 6'h08;
   localparam logic [5:0] PIO_PORT_B_DIRECTION = 6'h09;
   localparam logic [5:0] PIO_PORT_B_OPTION = 6'h0A;
   localparam logic [5:0] PIO_PORT_E_DATA = 6'h0C;
   localparam logic [5:0] PIO_PORT_E_DIRECTION = 6'h0D;
   localparam logic [5:0] PIO_PORT_E_OPTION = 6'h0E;
   localparam logic [5:0] PIO_PORT_D_DATA = 6'h10;
   localparam logic [5:0] PIO_PORT_D_DIRECTION = 6'h11;
   localparam logic [5:0] PIO_PORT_D_OPTION = 6'h12;
   localparam logic [5:0] PIO_PORT_F_DATA = 6'h14;
   localparam logic [5:0] PIO_PORT_F_DIRECTION = 6'h15;
   localparam logic [5:0] PIO_PORT_F_OPTION = 6'h16;
   localparam logic [5:0] PIO_IRQ_STATUS = 6'h18;
   localparam logic [5:0] PIO_IRQ_MASK = 6'h19;

   // Slot of each register inside a port's group of four indices.
   localparam logic [1:0] PIO_SLOT_DATA = 2'h0;
   localparam logic [1:0] PIO_SLOT_DIR = 2'h1;
   localparam logic [1:0] PIO_SLOT_OPT = 2'h2;
   localparam logic [2:0] PIO_PORT_IRQREGS = 3'h6;

   // Reset values before the forcing of unbonded bits.
   localparam logic [7:0] PIO_DATA_RST = 8'h00;
   localparam logic [7:0] PIO_DIR_RST = 8'h00;
   localparam logic [7:0] PIO_OPT_RST = 8'h00;
   localparam logic [3:0] PIO_IRQ_RST = 4'h0;

   // Per-port features, listed in reverse address order F, D, E, B, C, A (index 5 first).
   localparam logic [5:0][7:0] PIO_BONDED = {8'hD7, 8'hFF, 8'hF3, 8'hFF, 8'hFF, 8'hFF};
   localparam logic [5:0][7:0] PIO_IRQ_CAP = {8'h07, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h0F};
   localparam logic [5:0][7:0] PIO_HIGH_SINK = {8'h00, 8'h00, 8'hF0, 8'h00, 8'h00, 8'hF0};
   localparam logic [5:0] PIO_HAS_OPT = 6'h3F;

   // Pins of the bank that share one interrupt vector.
   localparam logic [3:0][47:0] PIO_GRP_MASK = {
      48'h0000_00F0_0000, 48'h0000_000F_0000, 48'h0700_0000_0000, 48'h0000_0000_000F};

endpackage : pio_pkg

//--- pio_port.sv
// One 8-bit port: data, direction and option registers with pin control.
`timescale 1ns/10ps
module pio_port #(
   parameter logic [7:0] BONDED = 8'hFF,
   parameter logic [7:0] IRQ_CAP = 8'h00,
   parameter logic [7:0] HIGH_SINK = 8'h00,
   parameter logic HAS_OPT = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wr_data,
   input wire logic wr_dir,
   input wire logic wr_opt,
   input wire logic [7:0] wdata,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] alt_en,
   input wire logic [7:0] alt_out,
   output logic [7:0] data_rd,
   output logic [7:0] dir,
   output logic [7:0] opt,
   output logic [7:0] pin_sync,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pin_pullup,
   output logic [7:0] pin_irq_en
);

   logic [7:0] data_latch;
   logic [7:0] pin_meta;
   logic [7:0] eff_opt;
   logic [7:0] out_mode;
   logic [7:0] push_pull;
   logic [7:0] drive_val;
   logic [7:0] next_out;
   logic [7:0] next_oe;
   logic [7:0] next_pullup;
   logic [7:0] next_irq_en;

   // Unbonded bits are forced high in every register, at reset too.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         data_latch <= pio_pkg::PIO_DATA_RST | ~BONDED;
         dir <= pio_pkg::PIO_DIR_RST | ~BONDED;
         opt <= pio_pkg::PIO_OPT_RST | ~BONDED;
      end else begin
         if (wr_data) begin
            data_latch <= wdata | ~BONDED;
         end
         if (wr_dir) begin
            dir <= wdata | ~BONDED;
         end
         if (wr_opt) begin
            opt <= wdata | ~BONDED;
         end
      end
   end

   // Two flip-flops on the pins before anything reads their level.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
      end else begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
      end
   end

   // Output pins read back the latch, input pins the synchronised level.
   assign data_rd = ((dir & data_latch) | (~dir & pin_sync)) | ~BONDED;

   // A port without an option register behaves as if every option bit were 0.
   assign eff_opt = HAS_OPT ? opt : 8'h00;
   // A claiming peripheral turns its pin into an output regardless of direction.
   assign out_mode = (dir | alt_en) & BONDED;
   // High-sink pins ignore option 1, a reserved setting, and stay open drain unless a peripheral claims them.
   assign push_pull = alt_en | (eff_opt & ~HIGH_SINK);
   assign drive_val = (alt_en & alt_out) | (~alt_en & data_latch);
   // Open drain only ever pulls low: its enable follows a zero on the latch.
   assign next_oe = out_mode & (push_pull | ~drive_val);
   assign next_out = out_mode & push_pull & drive_val;
   // Pull-up and interrupt only for inputs with option 1, never on high-sink pins.
   assign next_pullup = ~out_mode & eff_opt & ~HIGH_SINK & BONDED;
   assign next_irq_en = next_pullup & IRQ_CAP;

   // Pin controls leave through flip-flops so the pads see no decode glitches.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pin_out <= 8'h00;
         pin_oe <= 8'h00;
         pin_pullup <= 8'h00;
         pin_irq_en <= 8'h00;
      end else begin
         pin_out <= next_out;
         pin_oe <= next_oe;
         pin_pullup <= next_pullup;
         pin_irq_en <= next_irq_en;
      end
   end

endmodule : pio_port

//--- pio_bank.sv
// Parallel I/O port bank: APB register slave, six ports and interrupt grouping.
//
// Overview of operation
// - Direction bit 0 input, 1 output; reset input.
// - Data writes always update the output latch.
// - Data read: latch if output, pin if input.
// - Input option: 0 floating, 1 pull-up with interrupt.
// - Output option: 0 open drain, 1 push-pull.
// - Unbonded pin bits forced to one, reset included.
// - High-sink E inputs: option 1 reserved, floating used.
// - High-sink E outputs: open drain unless claimed, option 1 reserved.
// - Three registers per port, bases four apart.
// - Interrupt pins of one vector are ANDed.
// - Output pins contribute no interrupt request.
// - Peripheral claim overrides registers, forces output.
`timescale 1ns/10ps
module pio_bank (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [47:0] pin_in,
   output logic [47:0] pin_out,
   output logic [47:0] pin_oe,
   output logic [47:0] pin_pullup,
   input wire logic [47:0] alt_en,
   input wire logic [47:0] alt_out,
   output logic [47:0] pin_irq_en,
   output logic [3:0] ext_irq_level,
   output logic irq
);

   // Bus decode.
   logic [5:0] reg_index;
   logic [2:0] port_sel;
   logic [1:0] slot_sel;
   logic port_hit;
   logic status_hit;
   logic mask_hit;
   logic addr_ok;
   logic setup_phase;
   logic access_wr;

   // Per-port signals gathered into bank-wide vectors.
   logic [5:0][7:0] port_data_rd;
   logic [5:0][7:0] port_dir;
   logic [5:0][7:0] port_opt;
   logic [5:0][7:0] port_sync;
   logic [5:0][7:0] port_out;
   logic [5:0][7:0] port_oe;
   logic [5:0][7:0] port_pullup;
   logic [5:0][7:0] port_irq_en;
   logic [5:0] wr_data_sel;
   logic [5:0] wr_dir_sel;
   logic [5:0] wr_opt_sel;
   logic [47:0] sync_flat;
   logic [47:0] irq_en_flat;

   // Read path.
   logic [7:0] port_rd_byte;
   logic [7:0] rd_byte;
   logic [31:0] next_prdata;

   // Interrupt vectors and their sticky status.
   logic [3:0] grp_level;
   logic [3:0] grp_prev;
   logic [3:0] grp_fall;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic [3:0] status_clr;
   logic [3:0] next_status;
   logic err_q;

   // The index of a register is the byte address divided by four.
   assign reg_index = paddr[7:2];
   assign port_sel = reg_index[4:2];
   assign slot_sel = reg_index[1:0];
   assign port_hit = !reg_index[5] && (port_sel < 3'(pio_pkg::PIO_NUM_PORTS))
                     && (slot_sel != 2'h3);
   assign status_hit = (reg_index == pio_pkg::PIO_IRQ_STATUS);
   assign mask_hit = (reg_index == pio_pkg::PIO_IRQ_MASK);
   assign addr_ok = port_hit || status_hit || mask_hit;
   assign setup_phase = psel && !penable;
   // Writes take effect only at the access-phase edge, which is always the last.
   assign access_wr = psel && penable && pwrite;

   // Write strobes for each port, one per register slot.
   genvar gp;
   generate
      for (gp = 0; gp < pio_pkg::PIO_NUM_PORTS; gp++) begin : g_port
         assign wr_data_sel[gp] = access_wr && port_hit && (port_sel == 3'(gp))
                                  && (slot_sel == pio_pkg::PIO_SLOT_DATA);
         assign wr_dir_sel[gp] = access_wr && port_hit && (port_sel == 3'(gp))
                                 && (slot_sel == pio_pkg::PIO_SLOT_DIR);
         assign wr_opt_sel[gp] = access_wr && port_hit && (port_sel == 3'(gp))
                                 && (slot_sel == pio_pkg::PIO_SLOT_OPT)
                                 && pio_pkg::PIO_HAS_OPT[gp];

         pio_port #(
            .BONDED(pio_pkg::PIO_BONDED[gp]),
            .IRQ_CAP(pio_pkg::PIO_IRQ_CAP[gp]),
            .HIGH_SINK(pio_pkg::PIO_HIGH_SINK[gp]),
            .HAS_OPT(pio_pkg::PIO_HAS_OPT[gp])
         ) u_port (
            .clk(clk),
            .resetn(resetn),
            .wr_data(wr_data_sel[gp]),
            .wr_dir(wr_dir_sel[gp]),
            .wr_opt(wr_opt_sel[gp]),
            .wdata(pwdata[7:0]),
            .pin_in(pin_in[gp*8 +: 8]),
            .alt_en(alt_en[gp*8 +: 8]),
            .alt_out(alt_out[gp*8 +: 8]),
            .data_rd(port_data_rd[gp]),
            .dir(port_dir[gp]),
            .opt(port_opt[gp]),
            .pin_sync(port_sync[gp]),
            .pin_out(port_out[gp]),
            .pin_oe(port_oe[gp]),
            .pin_pullup(port_pullup[gp]),
            .pin_irq_en(port_irq_en[gp])
         );

         assign pin_out[gp*8 +: 8] = port_out[gp];
         assign pin_oe[gp*8 +: 8] = port_oe[gp];
         assign pin_pullup[gp*8 +: 8] = port_pullup[gp];
         assign sync_flat[gp*8 +: 8] = port_sync[gp];
         assign irq_en_flat[gp*8 +: 8] = port_irq_en[gp];
      end
   endgenerate

   assign pin_irq_en = irq_en_flat;

   // Register selection for a read; unmapped slots read as zero.
   always_comb begin
      port_rd_byte = 8'h00;
      if (port_hit) begin
         unique case (slot_sel)
            pio_pkg::PIO_SLOT_DATA: port_rd_byte = port_data_rd[port_sel];
            pio_pkg::PIO_SLOT_DIR: port_rd_byte = port_dir[port_sel];
            pio_pkg::PIO_SLOT_OPT: port_rd_byte = port_opt[port_sel];
            default: port_rd_byte = 8'h00;
         endcase
      end
   end

   assign rd_byte = status_hit ? {4'h0, irq_status} :
                    mask_hit ? {4'h0, irq_mask} : port_rd_byte;
   assign next_prdata = {24'h000000, rd_byte};

   // Read data are caught in the setup cycle so that the answer leaves a flip-flop;
   // the price is that a pin read shows the level one cycle before the access edge.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
         err_q <= 1'b0;
      end else if (setup_phase) begin
         prdata <= pwrite ? 32'h0000_0000 : next_prdata;
         err_q <= !addr_ok;
      end
   end

   // Every access completes in its first access cycle; unmapped ones are flagged.
   assign pready = 1'b1;
   assign pslverr = psel && penable && err_q;

   // Pins sharing a vector are ANDed; pins not enabled for interrupt count as high,
   // so a single interrupt input tied low masks every other one of its vector.
   genvar gg;
   generate
      for (gg = 0; gg < pio_pkg::PIO_NUM_GRP; gg++) begin : g_grp
         assign grp_level[gg] = &(sync_flat | ~(irq_en_flat & pio_pkg::PIO_GRP_MASK[gg]));
      end
   endgenerate

   assign ext_irq_level = grp_level;
   assign grp_fall = grp_prev & ~grp_level;
   assign status_clr = (access_wr && status_hit) ? pwdata[3:0] : 4'h0;
   // A falling edge in the same cycle as its clear keeps the bit set.
   assign next_status = (irq_status & ~status_clr) | grp_fall;

   // Vector history, sticky status and mask.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         grp_prev <= 4'hF;
         irq_status <= pio_pkg::PIO_IRQ_RST;
         irq_mask <= pio_pkg::PIO_IRQ_RST;
      end else begin
         grp_prev <= grp_level;
         irq_status <= next_status;
         if (access_wr && mask_hit) begin
            irq_mask <= pwdata[3:0];
         end
      end
   end

   // Level interrupt while any unmasked status bit stands.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_status & irq_mask);
      end
   end

endmodule : pio_bank

//--- pio_bank_checker.sv
// Concurrent checks on the port bank's bus and pin outputs.
`timescale 1ns/10ps
module pio_bank_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [47:0] pin_out,
   input wire logic [47:0] pin_oe,
   input wire logic [47:0] pin_pullup,
   input wire logic [47:0] alt_en,
   input wire logic [47:0] alt_out,
   input wire logic [47:0] pin_irq_en,
   input wire logic [3:0] ext_irq_level,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Bank masks are flattened once so each check stays on one line.
   wire logic [47:0] cap = pio_pkg::PIO_IRQ_CAP;
   wire logic [47:0] hs = pio_pkg::PIO_HIGH_SINK;
   wire logic [5:0] idx = paddr[7:2];
   wire logic mapped = (idx <= 6'h16 && idx[1:0] != 2'h3) || idx == 6'h18 || idx == 6'h19;
   logic [3:0] grp_off;
   // A vector with no enabled pin has nothing to pull its AND low.
   always_comb begin
      for (int g = 0; g < 4; g++) begin
         grp_off[g] = ~|(pin_irq_en & pio_pkg::PIO_GRP_MASK[g]);
      end
   end
   chk_ready_access: assert property (psel && penable |-> pready)
      else $error("no ready in access phase");
   chk_error_map: assert property (psel && penable |-> pslverr == !mapped)
      else $error("error response disagrees with address map");
   chk_irq_not_out: assert property ((pin_irq_en & pin_oe) == 48'h0)
      else $error("driven pin still requests interrupts");
   chk_irq_pullup: assert property ((pin_irq_en & ~pin_pullup) == 48'h0)
      else $error("interrupt input without pull-up");
   chk_irq_capable: assert property ((pin_irq_en & ~cap) == 48'h0)
      else $error("interrupt enabled on incapable pin");
   chk_sink_no_pull: assert property ((pin_pullup & hs) == 48'h0)
      else $error("pull-up on high-sink pin");
   chk_sink_open_drain: assert property ((pin_out & hs & ~$past(alt_en)) == 48'h0)
      else $error("high-sink pin drives high");
   chk_group_idle: assert property ((grp_off & ~ext_irq_level) == 4'h0)
      else $error("idle vector level low");
   chk_reset_quiet: assert property ($rose(resetn) |-> !irq && pin_oe == 48'h0)
      else $error("outputs active after reset");
   chk_alt_override: assert property ($past(resetn) |->
      ($past(alt_en) & ~pin_oe) == 48'h0
      && (($past(alt_out) ^ pin_out) & $past(alt_en)) == 48'h0)
      else $error("peripheral claim not driven");
endmodule : pio_bank_checker

//--- pio_board.sv
// Board model of the bank's pins: drivers, pull-ups and floating lines.
`timescale 1ns/10ps
module pio_board (
   input wire logic clk,
   input wire logic [47:0] pin_out,
   input wire logic [47:0] pin_oe,
   input wire logic [47:0] pin_pullup,
   input wire logic [47:0] ext_drv,
   input wire logic [47:0] ext_val,
   output logic [47:0] pin_in
);
   logic [47:0] drift = 48'h0;
   // A floating line wanders every cycle so no test leans on a settled unknown.
   // A plain always keeps the start value legal beside the clocked update.
   always @(posedge clk) begin
      drift <= ~drift;
   end
   // The device wins, then an outside driver, then the pull-up.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
      | (~pin_oe & ~ext_drv & (pin_pullup | drift));
endmodule : pio_board

//--- tb_top.sv
// Self-checking bench for the parallel I/O port bank.
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic pready, pslverr, irq, se;
   logic [47:0] pin_in, pin_out, pin_oe, pin_pullup, pin_irq_en;
   logic [47:0] alt_en = 48'h0;
   logic [47:0] alt_out = 48'h0;
   logic [47:0] ext_drv = 48'h0;
   logic [47:0] ext_val = 48'h0;
   logic [3:0] ext_irq_level;
   logic [7:0] b, h;
   int err_count = 0;
   int checked = 0;
   always #4 clk = ~clk;
   pio_bank pio_bank_inst (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pullup), .alt_en(alt_en), .alt_out(alt_out),
      .pin_irq_en(pin_irq_en), .ext_irq_level(ext_irq_level), .irq(irq));
   pio_board pio_board_inst (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pullup), .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));
   // Verdict and end of run.
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // One APB transfer; the request stands until ready is seen at an edge.
   task automatic apb(input logic [5:0] i, input logic w, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_count++;
         wrap_up();
      end
      q = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [5:0] i, input logic [7:0] e);
      apb(i, 1'b0, 8'h00);
      cmp(q, {24'h0, e});
   endtask : rd
   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
   endtask : ticks
   // The wait is bounded; a level that never comes ends the run.
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      while (irq !== v && n < 20) begin
         @(posedge clk);
         n++;
      end
      cmp(irq, v);
      if (irq !== v) wrap_up();
   endtask : wait_irq
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      for (int p = 0; p < 6; p++) begin
         b = pio_pkg::PIO_BONDED[p];
         rd(6'(p * 4 + 1), ~b);
         rd(6'(p * 4 + 2), ~b);
      end
      apb(6'h03, 1'b1, 8'hFF);
      cmp(se, 32'h1);
      rd(6'h1A, 8'h00);
      cmp(se, 32'h1);
      $display("test reset and map done");
      for (int p = 0; p < 6; p++) begin
         b = pio_pkg::PIO_BONDED[p];
         h = pio_pkg::PIO_HIGH_SINK[p];
         apb(6'(p * 4), 1'b1, 8'hA5);
         apb(6'(p * 4 + 2), 1'b1, 8'hFF);
         apb(6'(p * 4 + 1), 1'b1, 8'hFF);
         rd(6'(p * 4), 8'hA5 | ~b);
         ticks(3);
         cmp(pin_out[p*8 +: 8] & b, 8'hA5 & b & ~h);
         cmp(pin_oe[p*8 +: 8] & b, b & (~h | 8'h5A));
         apb(6'(p * 4 + 2), 1'b1, 8'h00);
         ticks(3);
         cmp(pin_oe[p*8 +: 8] & b, 8'h5A & b);
         cmp(pin_out[p*8 +: 8] & b, 32'h0);
      end
      $display("test outputs done");
      @(posedge clk);
      ext_drv <= {48{1'b1}};
      ext_val <= {6{8'h3C}};
      for (int p = 0; p < 6; p++) begin
         b = pio_pkg::PIO_BONDED[p];
         h = pio_pkg::PIO_HIGH_SINK[p];
         apb(6'(p * 4 + 1), 1'b1, ~b);
         ticks(4);
         rd(6'(p * 4), (8'h3C & b) | ~b);
      end
      @(posedge clk);
      ext_val <= {48{1'b1}};
      for (int p = 0; p < 6; p++) begin
         b = pio_pkg::PIO_BONDED[p];
         h = pio_pkg::PIO_HIGH_SINK[p];
         apb(6'(p * 4 + 2), 1'b1, 8'hFF);
         ticks(3);
         cmp(pin_pullup[p*8 +: 8] & b, b & ~h);
      end
      $display("test inputs done");
      apb(6'h18, 1'b1, 8'h0F);
      apb(6'h19, 1'b1, 8'h01);
      cmp(pin_irq_en[3:0], 32'hF);
      @(posedge clk);
      ext_val[0] <= 1'b0;
      wait_irq(1'b1);
      cmp(ext_irq_level[0], 32'h0);
      rd(6'h18, 8'h01);
      apb(6'h18, 1'b1, 8'h01);
      rd(6'h18, 8'h00);
      wait_irq(1'b0);
      apb(6'h19, 1'b1, 8'h00);
      @(posedge clk);
      ext_val[0] <= 1'b1;
      ticks(4);
      ext_val[0] <= 1'b0;
      ticks(6);
      rd(6'h18, 8'h01);
      cmp(irq, 32'h0);
      apb(6'h19, 1'b1, 8'h01);
      wait_irq(1'b1);
      apb(6'h18, 1'b1, 8'h01);
      wait_irq(1'b0);
      apb(6'h01, 1'b1, 8'hFF);
      ticks(3);
      cmp(pin_irq_en[7:0], 32'h0);
      cmp(ext_irq_level[0], 32'h1);
      $display("test interrupts done");
      @(posedge clk);
      alt_out[8] <= 1'b1;
      alt_en[8] <= 1'b1;
      ticks(3);
      cmp(pin_oe[8], 32'h1);
      cmp(pin_out[8], 32'h1);
      alt_en[8] <= 1'b0;
      $display("test alternate done");
      // A second reset in mid-run must drop the written port F option and port A direction registers back to their reset values.
      @(posedge clk);
      resetn <= 1'b0;
      ticks(4);
      resetn <= 1'b1;
      rd(6'h16, ~pio_pkg::PIO_BONDED[5]);
      rd(6'h01, 8'h00);
      cmp(pin_oe[7:0], 32'h0);
      cmp(irq, 32'h0);
      $display("test reset again done");
      wrap_up();
   end
endmodule : tb_top
bind pio_bank pio_bank_checker pio_bank_checker_inst (.clk(clk), .resetn(resetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .alt_en(alt_en),
   .alt_out(alt_out), .pin_irq_en(pin_irq_en), .ext_irq_level(ext_irq_level), .irq(irq));
